// *** hw/serial_flash_status_register.sv ***
/*
  Status register logic of a serial NOR flash: decodes frames on the
  serial link, keeps status_one and hands array operations to the array
  controller. The link is sampled by clk_sys_i, which must run at least
  four times faster than the serial clock; only clock mode 0 is handled.
  The array controller owns the array, the sector protection map and the
  non-volatile cells, and reports back through the op_* inputs.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Opcodes 05h read, 01h write, 30h clear errors.
// - Resets restore volatile bits; stored bits persist.
// - Lock bit with protect pin low blocks writes.
// - Pin high or lock clear allows register writes.
// - Failed or protected program sets program error.
// - Failed or protected sector erase sets erase error.
// - Whole erase hitting protection sets no error.
// - Error flags cleared only by clear-status or soft reset.
// - Nonzero protection range blocks program and erase.
// - Whole erase runs only with protection range zero.
// - Writes, programs, erases need write enable latch.
// - 06h sets latch, 04h clears, write data cannot set it.
// - Successful operation clears the write enable latch.
// - Any reset clears the write enable latch.
// - Busy flag reads one during any operation.
// - While busy only status, suspend, clear, reset.
// - Suspends accepted only during matching array operation.
// - Error keeps busy set until clear-status or soft reset.
// - Freeze bit locks current protection range.
module serial_flash_status_register
  import flash_status_pkg::*;
(
  input wire logic clk_sys_i, // system clock, 100 MHz
  input wire logic resetn_i, // hardware reset, active low
  input wire logic sck_i, // serial clock pin
  input wire logic cs_n_i, // chip select pin, active low
  input wire logic mosi_i, // serial data in
  input wire logic wp_n_i, // write protect pin, active low
  output logic miso_o, // serial data out
  output logic miso_oe_o, // high while miso_o is driven
  input wire logic cfg_bp_volatile_i, // protection range is volatile
  input wire logic cfg_freeze_i, // freeze bit of configuration
  input wire logic [7:0] nv_status_i, // stored non-volatile image
  input wire logic sector_protected_i, // op_addr_o is protected
  input wire logic otp_locked_i, // op_addr_o is a locked OTP region
  input wire logic op_done_i, // operation finished, pulse
  input wire logic op_fail_i, // with op_done_i: operation failed
  input wire logic op_prot_hit_i, // with op_done_i: met protection
  input wire logic op_suspended_i, // operation suspended, pulse
  output logic op_req_o, // start an operation, pulse
  output op_kind_e op_kind_o, // kind of current operation
  output logic [ADDR_BITS-1:0] op_addr_o, // frame address
  output logic [7:0] op_wdata_o, // new status_one for register write
  output logic [7:0] prog_byte_o, // program data byte
  output logic prog_byte_valid_o, // program data byte valid, pulse
  output logic erase_suspend_o, // erase suspend request, pulse
  output logic program_suspend_o, // program suspend request, pulse
  output logic soft_reset_o, // software reset request, pulse
  output logic [2:0] protect_range_o, // current protection range
  output logic [7:0] status_one_o // live status_one
);

  logic sck_s;
  logic cs_n_s;
  logic mosi_s;
  logic wp_n_s;
  logic sck_prev_reg;
  logic cs_n_prev_reg;
  logic sck_rise;
  logic sck_fall;
  logic frame_start;
  logic frame_end;

  pin_sync #(
    .WIDTH(4),
    .RESET_VALUE(4'hE)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .pin_i({wp_n_i, cs_n_i, mosi_i, sck_i}),
    .sync_o({wp_n_s, cs_n_s, mosi_s, sck_s})
  );

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_prev_reg <= 1'b0;
      cs_n_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      cs_n_prev_reg <= cs_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_prev_reg & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_prev_reg & ~cs_n_s;
  assign frame_start = cs_n_prev_reg & ~cs_n_s;
  assign frame_end = ~cs_n_prev_reg & cs_n_s;

  // Receive side: bits within a byte, then bytes within the frame.
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [6:0] rx_shift_reg;
  logic [7:0] opcode_reg;
  logic [7:0] wrr_data_reg;
  logic [ADDR_BITS-1:0] addr_reg;
  logic byte_done;
  logic [7:0] byte_val;

  assign byte_done = sck_rise & (bit_cnt_reg == BIT_LAST);
  assign byte_val = {rx_shift_reg, mosi_s};

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt_reg <= BIT_FIRST;
      rx_shift_reg <= '0;
    end else if (frame_start) begin
      bit_cnt_reg <= BIT_FIRST;
      rx_shift_reg <= '0;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_shift_reg <= byte_val[6:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byte_cnt_reg <= '0;
      opcode_reg <= '0;
      wrr_data_reg <= '0;
      addr_reg <= '0;
    end else if (frame_start) begin
      byte_cnt_reg <= '0;
    end else if (byte_done) begin
      if (byte_cnt_reg != BYTE_CNT_MAX) begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
      if (byte_cnt_reg == '0) begin
        opcode_reg <= byte_val;
      end else if (byte_cnt_reg < BYTES_ADDR_END) begin
        addr_reg <= {addr_reg[ADDR_BITS-9:0], byte_val};
      end
      if (byte_cnt_reg == BYTES_CMD_ONLY) begin
        wrr_data_reg <= byte_val;
      end
    end
  end

  // Status fields.
  logic write_lock_reg;
  logic prog_err_reg;
  logic erase_err_reg;
  logic [2:0] protect_reg;
  logic wel_reg;
  logic busy_reg;
  logic running_reg;
  logic nv_load_reg;
  op_kind_e run_kind_reg;
  logic [7:0] status_one;

  assign status_one = {write_lock_reg, prog_err_reg, erase_err_reg,
                       protect_reg, wel_reg, busy_reg};

  // Frame decode, acted on when chip select rises after whole bytes.
  logic frame_ok;
  logic accept_idle;
  logic hw_protected;
  logic do_write_enable_cmd;
  logic do_write_disable_cmd;
  logic do_clear_status_cmd;
  logic do_reset;
  logic do_wrr;
  logic do_prog;
  logic do_otp;
  logic do_se;
  logic do_be;
  logic do_erase_suspend_cmd;
  logic do_program_suspend_cmd;
  logic prog_blocked;
  logic erase_blocked;
  logic start_op;
  logic op_end;
  logic op_failed;
  logic op_ok;
  logic run_is_prog;
  logic run_is_erase;

  assign frame_ok = frame_end & (bit_cnt_reg == BIT_FIRST)
                    & (byte_cnt_reg != '0);
  assign accept_idle = frame_ok & ~busy_reg & ~nv_load_reg;
  assign hw_protected = write_lock_reg & ~wp_n_s;
  assign do_write_enable_cmd = accept_idle & (byte_cnt_reg == BYTES_CMD_ONLY)
                   & (opcode_reg == CMD_WRITE_ENABLE);
  assign do_write_disable_cmd = accept_idle & (byte_cnt_reg == BYTES_CMD_ONLY)
                   & (opcode_reg == CMD_WRITE_DISABLE);
  assign do_clear_status_cmd = frame_ok & (byte_cnt_reg == BYTES_CMD_ONLY)
                   & (opcode_reg == CMD_CLEAR_STATUS);
  assign do_reset = frame_ok & (byte_cnt_reg == BYTES_CMD_ONLY)
                    & (opcode_reg == CMD_SOFT_RESET);
  // A locked register write is refused whole, so no busy time is spent.
  assign do_wrr = accept_idle & wel_reg & ~hw_protected
                  & (byte_cnt_reg >= BYTES_WRR_MIN)
                  & (opcode_reg == CMD_WRITE_REGS);
  assign do_prog = accept_idle & wel_reg
                   & (byte_cnt_reg >= BYTES_PROG_MIN)
                   & (opcode_reg == CMD_PAGE_PROGRAM);
  assign do_otp = accept_idle & wel_reg
                  & (byte_cnt_reg >= BYTES_PROG_MIN)
                  & (opcode_reg == CMD_OTP_PROGRAM);
  assign do_se = accept_idle & wel_reg
                 & (byte_cnt_reg == BYTES_ADDR_END)
                 & (opcode_reg == CMD_SECTOR_ERASE);
  assign do_be = accept_idle & wel_reg & (protect_reg == PROTECT_NONE)
                 & (byte_cnt_reg == BYTES_CMD_ONLY)
                 & ((opcode_reg == CMD_WHOLE_ARRAY_ERASE)
                    | (opcode_reg == CMD_WHOLE_ARRAY_ERASE_ALT));
  assign run_is_prog = (run_kind_reg == OP_PROGRAM)
                       | (run_kind_reg == OP_OTP_PROGRAM);
  assign run_is_erase = (run_kind_reg == OP_SECTOR_ERASE)
                        | (run_kind_reg == OP_WHOLE_ERASE);
  assign do_erase_suspend_cmd = frame_ok & running_reg & run_is_erase
                   & (byte_cnt_reg == BYTES_CMD_ONLY)
                   & (opcode_reg == CMD_ERASE_SUSPEND);
  assign do_program_suspend_cmd = frame_ok & running_reg & run_is_prog
                   & (byte_cnt_reg == BYTES_CMD_ONLY)
                   & (opcode_reg == CMD_PROGRAM_SUSPEND);
  // The array controller maps the protection range onto sectors.
  assign prog_blocked = (do_prog & sector_protected_i)
                        | (do_otp & (otp_locked_i | cfg_freeze_i));
  assign erase_blocked = do_se & sector_protected_i;
  assign start_op = ((do_prog | do_otp) & ~prog_blocked)
                    | (do_se & ~erase_blocked) | do_be | do_wrr;
  assign op_end = op_done_i & running_reg;
  // Protection met during a whole erase is skipped, not an error.
  assign op_failed = op_fail_i
                     | (op_prot_hit_i
                        & (run_kind_reg != OP_WHOLE_ERASE));
  assign op_ok = op_end & ~op_failed;

  // Operation hand-off to the array controller.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_req_o <= 1'b0;
      run_kind_reg <= OP_NONE;
      op_wdata_o <= '0;
    end else begin
      op_req_o <= start_op;
      if (start_op) begin
        op_wdata_o <= wrr_data_reg;
        if (do_prog) begin
          run_kind_reg <= OP_PROGRAM;
        end else if (do_otp) begin
          run_kind_reg <= OP_OTP_PROGRAM;
        end else if (do_se) begin
          run_kind_reg <= OP_SECTOR_ERASE;
        end else if (do_be) begin
          run_kind_reg <= OP_WHOLE_ERASE;
        end else begin
          run_kind_reg <= OP_WRITE_REGS;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      erase_suspend_o <= 1'b0;
      program_suspend_o <= 1'b0;
      soft_reset_o <= 1'b0;
      prog_byte_valid_o <= 1'b0;
      prog_byte_o <= '0;
    end else begin
      erase_suspend_o <= do_erase_suspend_cmd;
      program_suspend_o <= do_program_suspend_cmd;
      soft_reset_o <= do_reset;
      prog_byte_valid_o <= byte_done & wel_reg & ~busy_reg
                           & (byte_cnt_reg >= BYTES_ADDR_END)
                           & ((opcode_reg == CMD_PAGE_PROGRAM)
                              | (opcode_reg == CMD_OTP_PROGRAM));
      if (byte_done) begin
        prog_byte_o <= byte_val;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      running_reg <= 1'b0;
    end else if (do_reset | op_end | op_suspended_i) begin
      running_reg <= 1'b0;
    end else if (start_op) begin
      running_reg <= 1'b1;
    end
  end

  // Busy covers running operations and any error left uncleared.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_reg <= 1'b0;
    end else if (do_reset) begin
      busy_reg <= 1'b0;
    end else if (start_op | prog_blocked | erase_blocked) begin
      busy_reg <= 1'b1;
    end else if (op_ok | (op_suspended_i & running_reg)) begin
      busy_reg <= 1'b0;
    end else if (do_clear_status_cmd & ~running_reg
                 & (prog_err_reg | erase_err_reg)) begin
      busy_reg <= 1'b0;
    end
  end

  // Error flags: a new error wins over a clear in the same cycle.
  logic prog_err_set;
  logic erase_err_set;

  assign prog_err_set = prog_blocked
                        | (op_end & op_failed & ~run_is_erase);
  assign erase_err_set = erase_blocked
                         | (op_end & op_failed & run_is_erase);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_err_reg <= 1'b0;
      erase_err_reg <= 1'b0;
    end else begin
      if (prog_err_set) begin
        prog_err_reg <= 1'b1;
      end else if (do_clear_status_cmd | do_reset) begin
        prog_err_reg <= 1'b0;
      end
      if (erase_err_set) begin
        erase_err_reg <= 1'b1;
      end else if (do_clear_status_cmd | do_reset) begin
        erase_err_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wel_reg <= 1'b0;
    end else if (do_write_enable_cmd) begin
      wel_reg <= 1'b1;
    end else if (do_write_disable_cmd | do_reset) begin
      wel_reg <= 1'b0;
    end else if (op_ok) begin
      wel_reg <= 1'b0;
    end
  end

  // Stored bits are reloaded from the non-volatile image after either
  // reset, because the asynchronous reset may only load constants.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nv_load_reg <= 1'b1;
    end else begin
      nv_load_reg <= do_reset;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      write_lock_reg <= 1'b0;
      protect_reg <= PROTECT_NONE;
    end else if (nv_load_reg) begin
      write_lock_reg <= nv_status_i[SR_WRITE_LOCK];
      if (cfg_bp_volatile_i) begin
        protect_reg <= PROTECT_VOLATILE_DEFAULT;
      end else begin
        protect_reg <= nv_status_i[SR_PROTECT_HI:SR_PROTECT_LO];
      end
    end else if (op_ok & (run_kind_reg == OP_WRITE_REGS)) begin
      write_lock_reg <= op_wdata_o[SR_WRITE_LOCK];
      if (!cfg_freeze_i) begin
        protect_reg <= op_wdata_o[SR_PROTECT_HI:SR_PROTECT_LO];
      end
    end
  end

  // Transmit side: status is reloaded at each byte boundary so that a
  // long polling read follows busy_flag as it changes.
  logic rd_mode_reg;
  logic rd_two_reg;
  logic [7:0] tx_shift_reg;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_mode_reg <= 1'b0;
      rd_two_reg <= 1'b0;
    end else if (frame_start) begin
      rd_mode_reg <= 1'b0;
      rd_two_reg <= 1'b0;
    end else if (byte_done & (byte_cnt_reg == '0)) begin
      rd_mode_reg <= (byte_val == CMD_READ_STATUS)
                     | (byte_val == CMD_READ_STATUS_TWO);
      rd_two_reg <= byte_val == CMD_READ_STATUS_TWO;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_shift_reg <= '0;
    end else if (byte_done) begin
      if (byte_cnt_reg == '0) begin
        tx_shift_reg <= (byte_val == CMD_READ_STATUS_TWO) ?
                        STATUS_TWO_VALUE : status_one;
      end else begin
        tx_shift_reg <= rd_two_reg ? STATUS_TWO_VALUE : status_one;
      end
    end else if (sck_fall & (bit_cnt_reg != BIT_FIRST)) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end
  end

  assign miso_o = tx_shift_reg[7];
  assign miso_oe_o = rd_mode_reg & ~cs_n_s;
  assign op_kind_o = run_kind_reg;
  assign op_addr_o = addr_reg;
  assign protect_range_o = protect_reg;
  assign status_one_o = status_one;

endmodule

// *** hw/flash_status_pkg.sv ***
/*
  Shared constants for the serial flash status register block: command
  codes, status_one field positions, reset values, frame byte counts and
  the kinds of array operation handed to the array controller.
  Assumes a four-wire serial link in clock mode 0 and an array controller
  that executes the program, erase and non-volatile write operations.
*/
package flash_status_pkg;

  // Command codes seen as the first byte of a frame.
  localparam logic [7:0] CMD_WRITE_REGS = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
  localparam logic [7:0] CMD_OTP_PROGRAM = 8'h42;
  localparam logic [7:0] CMD_WHOLE_ARRAY_ERASE = 8'hC7;
  localparam logic [7:0] CMD_WHOLE_ARRAY_ERASE_ALT = 8'h60;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_PROGRAM_SUSPEND = 8'h85;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hF0;

  // Field positions inside status_one.
  localparam int SR_WRITE_LOCK = 7;
  localparam int SR_PROG_ERR = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROTECT_HI = 4;
  localparam int SR_PROTECT_LO = 2;
  localparam int SR_WEL = 1;
  localparam int SR_BUSY = 0;

  localparam logic [2:0] PROTECT_NONE = 3'h0;
  localparam logic [2:0] PROTECT_VOLATILE_DEFAULT = 3'h7;
  localparam logic [7:0] STATUS_TWO_VALUE = 8'h00;

  // Frame lengths in whole bytes, opcode included, then bit positions in a byte.
  localparam logic [2:0] BYTES_CMD_ONLY = 3'h1;
  localparam logic [2:0] BYTES_WRR_MIN = 3'h2;
  localparam logic [2:0] BYTES_ADDR_END = 3'h4;
  localparam logic [2:0] BYTES_PROG_MIN = 3'h5;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  localparam int ADDR_BITS = 24;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_PROGRAM,
    OP_OTP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_WHOLE_ERASE,
    OP_WRITE_REGS
  } op_kind_e;

endpackage

// *** hw/pin_sync.sv ***
/*
  Two-stage synchroniser for a group of pins, one bit per generate entry.
  Assumes each pin is asynchronous to clk_sys_i; the first stage is read
  by the second stage only.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_sys_i, // system clock
  input wire logic resetn_i, // asynchronous reset, active low
  input wire logic [WIDTH-1:0] pin_i, // raw pin levels
  output logic [WIDTH-1:0] sync_o // synchronised levels
);

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_reg;
    logic sync_reg;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
        meta_reg <= RESET_VALUE[i];
        sync_reg <= RESET_VALUE[i];
      end else begin
        meta_reg <= pin_i[i];
        sync_reg <= meta_reg;
      end
    end
    assign sync_o[i] = sync_reg;
  end

endmodule

// *** sim/flash_status_props.sv ***
/*
  Port assertions for the status register block.
  Assumes one clock domain and a bind onto the block's top module.
*/
`timescale 1ns/1ps
module flash_status_props
  import flash_status_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic resetn_i, // reset, active low
  input wire logic cs_n_i, // chip select
  input wire logic op_done_i, // operation finished
  input wire logic op_fail_i, // operation failed
  input wire logic op_prot_hit_i, // operation met protection
  input wire logic op_req_o, // operation start
  input op_kind_e op_kind_o, // operation kind
  input wire logic erase_suspend_o, // erase suspend pulse
  input wire logic miso_oe_o, // miso driven
  input wire logic [2:0] protect_range_o, // protection range
  input wire logic [7:0] status_one_o // status_one
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_clean_done;
    op_done_i && !op_fail_i && !op_prot_hit_i && status_one_o[SR_BUSY];
  endsequence
  sequence s_prog_fail;
    op_done_i && op_fail_i && status_one_o[SR_BUSY]
      && op_kind_o == OP_PROGRAM;
  endsequence
  a_clean_done_ready: assert property (
    s_clean_done |=> !status_one_o[SR_BUSY] && !status_one_o[SR_WEL])
    else $error("busy or latch left set after clean completion");
  a_prog_fail_err: assert property (
    s_prog_fail |=> status_one_o[SR_PROG_ERR] && status_one_o[SR_BUSY])
    else $error("failed program did not flag an error");
  a_error_holds_busy: assert property (
    status_one_o[SR_PROG_ERR] || status_one_o[SR_ERASE_ERR]
      |-> status_one_o[SR_BUSY])
    else $error("error flag set while busy is clear");
  a_err_clear_idle: assert property (
    $fell(status_one_o[SR_PROG_ERR]) |-> !status_one_o[SR_BUSY])
    else $error("error cleared without return to standby");
  a_req_needs_wel: assert property (
    op_req_o |-> status_one_o[SR_WEL])
    else $error("operation started without write enable");
  a_req_sets_busy: assert property (
    op_req_o |-> ##[0:1] status_one_o[SR_BUSY])
    else $error("operation started without busy");
  a_whole_erase_clear: assert property (
    op_req_o && op_kind_o == OP_WHOLE_ERASE
      |-> protect_range_o == PROTECT_NONE)
    else $error("whole erase started with protection set");
  a_whole_no_error: assert property (
    op_done_i && op_prot_hit_i && !op_fail_i
      && op_kind_o == OP_WHOLE_ERASE |=> !status_one_o[SR_ERASE_ERR])
    else $error("whole erase set the erase error");
  a_suspend_match: assert property (
    erase_suspend_o |-> status_one_o[SR_BUSY]
      && op_kind_o inside {OP_SECTOR_ERASE, OP_WHOLE_ERASE})
    else $error("erase suspend without a running erase");
  a_wel_rise_idle: assert property (
    $rose(status_one_o[SR_WEL]) |-> !status_one_o[SR_BUSY])
    else $error("write enable accepted while busy");
  a_miso_idle_quiet: assert property (
    cs_n_i [*6] |-> !miso_oe_o)
    else $error("miso driven while deselected");
endmodule

bind serial_flash_status_register flash_status_props u_props (
  .clk_sys_i, .resetn_i, .cs_n_i, .op_done_i, .op_fail_i,
  .op_prot_hit_i, .op_req_o, .op_kind_o, .erase_suspend_o,
  .miso_oe_o, .protect_range_o, .status_one_o
);

// *** sim/flash_host_model.sv ***
/*
  Host controller model framing commands on the serial link.
  Assumes clock mode 0 and an 80 ns serial clock period.
*/
`timescale 1ns/1ps
module flash_host_model (
  input wire logic miso_i, // data from device
  input wire logic miso_oe_i, // device drives miso_i
  output logic sck_o, // serial clock, idle low
  output logic cs_n_o, // chip select, active low
  output logic mosi_o // data to device
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Sampling mid high phase stays clear of the device's output update,
  // which lands about three clk_sys_i cycles after each falling edge.
  task automatic frame(input logic [39:0] d, input int n,
    output logic [7:0] rx);
    rx = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      mosi_o = d[39 - i];
      #40;
      sck_o = 1'b1;
      #20;
      rx = {rx[6:0], miso_oe_i ? miso_i : 1'bx};
      #20;
      sck_o = 1'b0;
    end
    #40;
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #80;
  endtask
endmodule

// *** sim/serial_flash_status_register_tb.sv ***
/*
  Self-checking bench for the status register block.
  Assumes the host model drives the link and the bench plays the array.
*/
`timescale 1ns/1ps
module serial_flash_status_register_tb
  import flash_status_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wp_n_i = 1'b0;
  logic cfg_bp_volatile_i = 1'b0;
  logic [7:0] nv_status_i = 8'h8C;
  logic sector_protected_i = 1'b0;
  logic [3:0] arr_v = 4'h0;
  logic sck, cs_n, mosi, miso, miso_oe, op_req, esp, psp, srst, pbv;
  logic frz = 1'b0;
  op_kind_e op_kind;
  logic [7:0] wdata, st, pbyte;
  logic [23:0] addr;
  logic [2:0] prange;
  int n_errors = 0;
  int n_compared = 0;
  int n_req = 0;
  int n_esp = 0;
  int n_psp = 0;
  int n_srst = 0;
  int n_pbv = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    n_req <= n_req + int'(op_req);
    n_esp <= n_esp + int'(esp);
    n_psp <= n_psp + int'(psp);
    n_srst <= n_srst + int'(srst);
    n_pbv <= n_pbv + int'(pbv);
  end
  flash_host_model u_host (.miso_i(miso), .miso_oe_i(miso_oe),
    .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
  serial_flash_status_register u_dut (.clk_sys_i, .resetn_i,
    .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .wp_n_i,
    .miso_o(miso), .miso_oe_o(miso_oe), .cfg_bp_volatile_i,
    .cfg_freeze_i(frz), .nv_status_i, .sector_protected_i,
    .otp_locked_i(sector_protected_i), .op_done_i(arr_v[3]),
    .op_fail_i(arr_v[2]), .op_prot_hit_i(arr_v[1]),
    .op_suspended_i(arr_v[0]),
    .op_req_o(op_req), .op_kind_o(op_kind), .op_addr_o(addr),
    .op_wdata_o(wdata), .prog_byte_o(pbyte), .prog_byte_valid_o(pbv),
    .erase_suspend_o(esp), .program_suspend_o(psp),
    .soft_reset_o(srst), .protect_range_o(prange), .status_one_o(st));
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] op, input logic [31:0] d,
    input int n);
    logic [7:0] r;
    u_host.frame({op, d}, n, r);
  endtask
  task automatic rd(input string what, input logic [7:0] exp);
    logic [7:0] r;
    u_host.frame({CMD_READ_STATUS, 32'h0}, 2, r);
    chk(what, exp, r);
    chk(what, exp, st);
  endtask
  // One-cycle array answer: done, fail, protection hit, suspended.
  task automatic arr(input logic [3:0] v);
    @(posedge clk_sys_i);
    #1;
    arr_v = v;
    @(posedge clk_sys_i);
    #1;
    arr_v = 4'h0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic t_wel;
    send(CMD_WRITE_ENABLE, 32'h0, 1);
    rd("wel set", 8'h8E);
    send(CMD_WRITE_DISABLE, 32'h0, 1);
    rd("wel clear", 8'h8C);
  endtask
  task automatic t_lock;
    int r;
    r = n_req;
    send(CMD_WRITE_ENABLE, 32'h0, 1);
    send(CMD_WRITE_REGS, 32'h0, 2);
    chk("locked req", 8'(r), 8'(n_req));
    rd("locked", 8'h8E);
    wp_n_i = 1'b1;
    send(CMD_WRITE_REGS, 32'h0, 2);
    chk("wrr req", 8'(r + 1), 8'(n_req));
    chk("wrr kind", 8'(OP_WRITE_REGS), 8'(op_kind));
    chk("wrr data", 8'h00, wdata);
    rd("wrr busy", 8'h8F);
    arr(4'h8);
    rd("wrr done", 8'h00);
  endtask
  task automatic t_prog;
    int r;
    r = n_req;
    send(CMD_PAGE_PROGRAM, 32'h000100A5, 5);
    chk("no wel req", 8'(r), 8'(n_req));
    send(CMD_WRITE_ENABLE, 32'h0, 1);
    send(CMD_PAGE_PROGRAM, 32'h000100A5, 5);
    chk("prog req", 8'(r + 1), 8'(n_req));
    chk("prog addr", 8'h01, addr[15:8]);
    chk("prog byte", 8'hA5, pbyte);
    chk("prog valid", 8'h01, 8'(n_pbv));
    send(CMD_WRITE_DISABLE, 32'h0, 1);
    rd("busy drop", 8'h03);
    arr(4'hC);
    rd("prog err", 8'h43);
    send(CMD_WRITE_REGS, 32'h0C000000, 2);
    chk("err req", 8'(r + 1), 8'(n_req));
    send(CMD_CLEAR_STATUS, 32'h0, 1);
    rd("clear", 8'h02);
    send(CMD_WRITE_DISABLE, 32'h0, 1);
    rd("disable", 8'h00);
  endtask
  task automatic t_erase;
    int r;
    r = n_req;
    send(CMD_WRITE_ENABLE, 32'h0, 1);
    sector_protected_i = 1'b1;
    send(CMD_SECTOR_ERASE, 32'h04000000, 4);
    chk("prot req", 8'(r), 8'(n_req));
    rd("erase err", 8'h23);
    send(CMD_CLEAR_STATUS, 32'h0, 1);
    send(CMD_OTP_PROGRAM, 32'h000000A5, 5);
    rd("otp err", 8'h43);
    sector_protected_i = 1'b0;
    send(CMD_CLEAR_STATUS, 32'h0, 1);
    send(CMD_WHOLE_ARRAY_ERASE, 32'h0, 1);
    chk("whole req", 8'(r + 1), 8'(n_req));
    arr(4'hA);
    rd("whole hit", 8'h00);
  endtask
  task automatic t_suspend;
    int e;
    int p;
    e = n_esp;
    p = n_psp;
    send(CMD_WRITE_ENABLE, 32'h0, 1);
    send(CMD_SECTOR_ERASE, 32'h04000000, 4);
    send(CMD_PROGRAM_SUSPEND, 32'h0, 1);
    chk("psp pulse", 8'(p), 8'(n_psp));
    send(CMD_ERASE_SUSPEND, 32'h0, 1);
    chk("esp pulse", 8'(e + 1), 8'(n_esp));
    arr(4'h1);
    rd("suspended", 8'h02);
  endtask
  task automatic t_range;
    int r;
    send(CMD_WRITE_REGS, 32'h0C000000, 2);
    arr(4'h8);
    rd("range", 8'h0C);
    chk("range out", 8'h03, {5'h0, prange});
    r = n_req;
    send(CMD_WRITE_ENABLE, 32'h0, 1);
    send(CMD_WHOLE_ARRAY_ERASE_ALT, 32'h0, 1);
    chk("whole blocked", 8'(r), 8'(n_req));
    rd("blocked", 8'h0E);
  endtask
  task automatic t_srst;
    int s;
    s = n_srst;
    cfg_bp_volatile_i = 1'b1;
    send(CMD_SOFT_RESET, 32'h0, 1);
    chk("srst pulse", 8'(s + 1), 8'(n_srst));
    rd("srst", 8'h9C);
    frz = 1'b1;
    send(CMD_WRITE_ENABLE, 32'h0, 1);
    send(CMD_WRITE_REGS, 32'h0, 2);
    arr(4'h8);
    rd("frozen", 8'h1C);
  endtask
  initial begin
    repeat (50000) @(posedge clk_sys_i);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #1;
    rd("reset", 8'h8C);
    t_wel();
    t_lock();
    t_prog();
    t_erase();
    t_suspend();
    t_range();
    t_srst();
    complete_run();
  end
endmodule
